// ==== inc/ttms_pkg.sv ====
package ttms_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] ADDR_MODE = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;

	// Mode register field positions
	localparam int MODE_LO_POS = 3;
	localparam int MODE_HI_POS = 4;
	localparam int MON_POS = 2;

	// Status register field positions
	localparam int ST_CRU_POS = 0;
	localparam int ST_FIFO_POS = 1;
	localparam int ST_LOOP_POS = 2;
	localparam int ST_GAIN_POS = 3;

	// Reset values
	localparam logic MON_RESET = 1'b0;
	localparam logic [7:0] MODE_RESET = 8'h00;

	// Strap decode codes
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_FLOAT = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;

	// Cycles after reset release before the strap is sampled
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

	// Serial transmit mode codes
	typedef enum logic [1:0] {
		TTMS_SYNC_FIFO = 2'b00,
		TTMS_PLESIO = 2'b01,
		TTMS_SYNC_CRU = 2'b10,
		TTMS_LOOP = 2'b11
	} ttms_mode_t;

endpackage

// ==== logic/ttms_strap_decode.sv ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Three-state strap decoder
// ----------------------------------------
// The strap is sensed twice: once with a weak pull-up and once with a weak
// pull-down applied. A floating pin follows the pull, a driven one does not.
module ttms_strap_decode (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic strap_in,
	output logic pull_up_en,
	output logic [1:0] strap_code,
	output logic strap_valid
);
	logic s1_reg, s2_reg, s1_next, s2_next;
	logic [1:0] cnt_reg, cnt_next;
	logic up_seen_reg, up_seen_next;
	logic [1:0] code_reg, code_next;
	logic valid_reg, valid_next;

	// Next state: sample high phase, then low phase, then decide
	always_comb begin
		s1_next = strap_in;
		s2_next = s1_reg;
		cnt_next = cnt_reg;
		up_seen_next = up_seen_reg;
		code_next = code_reg;
		valid_next = valid_reg;
		if (!valid_reg) begin
			cnt_next = cnt_reg + 2'h1;
			if (cnt_reg == ttms_pkg::STRAP_SETTLE) begin
				if (pull_up_en) begin
					up_seen_next = s2_reg;
				end else begin
					valid_next = 1'b1;
					if (up_seen_reg && !s2_reg)
						code_next = ttms_pkg::STRAP_FLOAT;
					else if (s2_reg)
						code_next = ttms_pkg::STRAP_HIGH;
					else
						code_next = ttms_pkg::STRAP_LOW;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			cnt_reg <= 2'h0;
			up_seen_reg <= 1'b0;
			code_reg <= ttms_pkg::STRAP_LOW;
			valid_reg <= 1'b0;
			pull_up_en <= 1'b1;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			cnt_reg <= cnt_next;
			up_seen_reg <= up_seen_next;
			code_reg <= code_next;
			valid_reg <= valid_next;
			if (!valid_reg && cnt_reg == ttms_pkg::STRAP_SETTLE)
				pull_up_en <= 1'b0;
		end
	end

	assign strap_code = code_reg;
	assign strap_valid = valid_reg;
endmodule

`default_nettype wire

// ==== logic/ttms_top.sv ====
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R1: Mode 01 routes data through clock recovery and bypasses the FIFO.
// R2: Mode 11 uses recovered receive clock for transmit DLL and FIFO.
// R3: In parallel operation only mode 11 changes timing, enabling loop timing.
// R4: After reset mode loads from strap: low 00, float 11, high 01.
// R5: Monitor enable resets to 0; set commands 20dB flat receive gain.
// R6: Monitor enable acts only in CMI line coding, never in NRZ.
// R7: In serial operation the mode field picks transmit clocking and routing.
// R8: Mode 00 passes clock and data through FIFO, clock recovery unused.
// R9: Mode 10 passes data through clock recovery, then the FIFO.
// R10: Mode and monitor fields stay writable; writes act without reset.
module ttms_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic clock_mode_strap,
	output logic strap_pull_up_en,
	input wire logic parallel_interface_select,
	input wire logic cmi_coding_sel,
	output logic cru_route_en,
	output logic fifo_route_en,
	output logic loop_timing_en,
	output logic rx_flat_gain_en
);
	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	logic [1:0] strap_code;
	logic strap_valid;
	logic pull_up_w;

	ttms_strap_decode u_strap (
		.core_clk(core_clk),
		.resetn(resetn),
		.strap_in(clock_mode_strap),
		.pull_up_en(pull_up_w),
		.strap_code(strap_code),
		.strap_valid(strap_valid)
	);

	// Strap code to default mode
	function automatic ttms_pkg::ttms_mode_t strap_to_mode(
		input logic [1:0] code
	);
		case (code)
			ttms_pkg::STRAP_FLOAT: strap_to_mode = ttms_pkg::TTMS_LOOP;
			ttms_pkg::STRAP_HIGH: strap_to_mode = ttms_pkg::TTMS_PLESIO;
			default: strap_to_mode = ttms_pkg::TTMS_SYNC_FIFO;
		endcase
	endfunction

	// ----------------------------------------
	// Pin synchronisers for level inputs
	// ----------------------------------------
	logic par_s1_reg, par_s2_reg, cmi_s1_reg, cmi_s2_reg;

	// Control pins may be moved by board logic in any clock domain
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			par_s1_reg <= 1'b0;
			par_s2_reg <= 1'b0;
			cmi_s1_reg <= 1'b0;
			cmi_s2_reg <= 1'b0;
		end else begin
			par_s1_reg <= parallel_interface_select;
			par_s2_reg <= par_s1_reg;
			cmi_s1_reg <= cmi_coding_sel;
			cmi_s2_reg <= cmi_s1_reg;
		end
	end

	// ----------------------------------------
	// Mode register and Wishbone slave
	// ----------------------------------------
	ttms_pkg::ttms_mode_t mode_reg, mode_next;
	logic mon_reg, mon_next;
	logic loaded_reg, loaded_next;
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic req;
	logic [7:0] mode_byte;
	logic [7:0] stat_byte;

	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign mode_byte = {3'h0, mode_reg, mon_reg, 2'h0};
	assign stat_byte = {4'h0, rx_flat_gain_en, loop_timing_en,
		fifo_route_en, cru_route_en};

	// Strap load once after reset, then software owns the fields
	always_comb begin
		mode_next = mode_reg;
		mon_next = mon_reg;
		loaded_next = loaded_reg;
		ack_next = req;
		dat_next = 32'h0000_0000;
		if (strap_valid && !loaded_reg) begin
			mode_next = strap_to_mode(strap_code); // R4
			loaded_next = 1'b1;
		end
		if (req && wb_we_i && wb_adr_i == ttms_pkg::ADDR_MODE
			&& wb_sel_i[0]) begin
			// Writes act immediately; a write racing the strap load wins
			mode_next = ttms_pkg::ttms_mode_t'(
				wb_dat_i[ttms_pkg::MODE_HI_POS:ttms_pkg::MODE_LO_POS]); // R10
			mon_next = wb_dat_i[ttms_pkg::MON_POS]; // R10
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				ttms_pkg::ADDR_MODE: dat_next = {24'h0, mode_byte};
				ttms_pkg::ADDR_STAT: dat_next = {24'h0, stat_byte};
				default: dat_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			mode_reg <= ttms_pkg::TTMS_SYNC_FIFO;
			mon_reg <= ttms_pkg::MON_RESET; // R5
			loaded_reg <= 1'b0;
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			mode_reg <= mode_next;
			mon_reg <= mon_next;
			loaded_reg <= loaded_next;
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	// ----------------------------------------
	// Transmit timing path decode
	// ----------------------------------------
	logic cru_next, fifo_next, loop_next, gain_next;

	// Parallel mode only honours loop timing; paths follow serial mode
	always_comb begin
		cru_next = 1'b0;
		fifo_next = 1'b0;
		loop_next = 1'b0;
		if (par_s2_reg) begin
			loop_next = (mode_reg == ttms_pkg::TTMS_LOOP); // R3
			fifo_next = 1'b1;
		end else begin
			case (mode_reg) // R7
				ttms_pkg::TTMS_SYNC_FIFO: begin
					fifo_next = 1'b1; // R8
				end
				ttms_pkg::TTMS_PLESIO: begin
					cru_next = 1'b1; // R1
				end
				ttms_pkg::TTMS_SYNC_CRU: begin
					cru_next = 1'b1; // R9
					fifo_next = 1'b1; // R9
				end
				ttms_pkg::TTMS_LOOP: begin
					loop_next = 1'b1; // R2
					fifo_next = 1'b1; // R2
				end
				default: fifo_next = 1'b1;
			endcase
		end
		// Gain stage exists only in the CMI front end
		gain_next = mon_reg && cmi_s2_reg; // R5 R6
	end

	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			cru_route_en <= 1'b0;
			fifo_route_en <= 1'b0;
			loop_timing_en <= 1'b0;
			rx_flat_gain_en <= 1'b0;
			strap_pull_up_en <= 1'b1;
		end else begin
			cru_route_en <= cru_next;
			fifo_route_en <= fifo_next;
			loop_timing_en <= loop_next;
			rx_flat_gain_en <= gain_next;
			strap_pull_up_en <= pull_up_w;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	chk_plesio_path: assert property ( // R1
		!par_s2_reg && mode_reg == ttms_pkg::TTMS_PLESIO
		|=> cru_route_en && !fifo_route_en)
		else $error("plesiochronous path wrong");
	chk_loop_serial: assert property ( // R2
		!par_s2_reg && mode_reg == ttms_pkg::TTMS_LOOP
		|=> loop_timing_en && fifo_route_en && !cru_route_en)
		else $error("serial loop timing wrong");
	chk_par_loop: assert property ( // R3
		par_s2_reg |=> loop_timing_en == ($past(mode_reg) == 2'b11)
		&& !cru_route_en)
		else $error("parallel loop timing wrong");
	chk_strap_load: assert property ( // R4
		strap_valid && !loaded_reg && !(req && wb_we_i)
		|=> mode_reg == strap_to_mode($past(strap_code)))
		else $error("strap default not loaded");
	chk_gain_cmi: assert property ( // R6
		rx_flat_gain_en |-> $past(mon_reg) && $past(cmi_s2_reg))
		else $error("gain outside CMI or monitor");
	chk_gain_on: assert property ( // R5
		mon_reg && cmi_s2_reg |=> rx_flat_gain_en)
		else $error("monitor gain not applied");
	chk_sync_fifo: assert property ( // R8
		!par_s2_reg && mode_reg == ttms_pkg::TTMS_SYNC_FIFO
		|=> fifo_route_en && !cru_route_en && !loop_timing_en)
		else $error("sync fifo path wrong");
	chk_sync_cru: assert property ( // R9
		!par_s2_reg && mode_reg == ttms_pkg::TTMS_SYNC_CRU
		|=> fifo_route_en && cru_route_en && !loop_timing_en)
		else $error("sync cru path wrong");
	chk_write_mode: assert property ( // R10
		req && wb_we_i && wb_adr_i == ttms_pkg::ADDR_MODE && wb_sel_i[0]
		|=> mode_reg == $past(wb_dat_i[4:3]) && wb_ack_o ##1 !wb_ack_o)
		else $error("mode write not applied");

	cov_loop: cover property (loop_timing_en);
	cov_plesio: cover property (cru_route_en && !fifo_route_en);
	cov_gain: cover property (rx_flat_gain_en);
	cov_strap_float: cover property (strap_valid
		&& strap_code == ttms_pkg::STRAP_FLOAT);
endmodule

`default_nettype wire

// ==== test/ttms_strap_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Three-state strap pin model
// ----------------------------------------
module ttms_strap_model (
	input wire logic [1:0] level_sel,
	input wire logic pull_up_en,
	output logic pin
);
	// A floating pin follows the weak pull, a driven pin ignores it
	always_comb begin
		case (level_sel)
			ttms_pkg::STRAP_LOW: pin = 1'b0;
			ttms_pkg::STRAP_HIGH: pin = 1'b1;
			default: pin = pull_up_en;
		endcase
	end
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none

module testbench;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack;
	logic [1:0] strap_sel = 2'h0;
	logic par = 1'b0;
	logic cmi = 1'b0;
	logic strap_pin, pull_up, cru, fifo, loop_t, gain;
	logic [31:0] q;
	logic [4:0] v;
	logic [1:0] straps [3] = '{ttms_pkg::STRAP_LOW, ttms_pkg::STRAP_FLOAT,
		ttms_pkg::STRAP_HIGH};
	logic [1:0] dflt [3] = '{2'h0, 2'h3, 2'h1};
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;

	ttms_top u_ttms_top (.core_clk(core_clk), .resetn(resetn),
		.wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack),
		.clock_mode_strap(strap_pin), .strap_pull_up_en(pull_up),
		.parallel_interface_select(par), .cmi_coding_sel(cmi),
		.cru_route_en(cru), .fifo_route_en(fifo),
		.loop_timing_en(loop_t), .rx_flat_gain_en(gain));

	ttms_strap_model u_ttms_strap_model (.level_sel(strap_sel),
		.pull_up_en(pull_up), .pin(strap_pin));

	// 100 ns clock
	initial begin
		forever #50 core_clk = ~core_clk;
	end

	// Hang guard: the whole run needs about 850 cycles
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			close_out();
		end
	end

	// ----------------------------------------
	// Tasks and expectations
	// ----------------------------------------
	// Classic cycle: hold until ack is sampled, then idle one cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge core_clk);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_sel <= s;
		wb_dat_i <= d;
		@(posedge core_clk);
		while (wb_ack !== 1'b1) @(posedge core_clk);
		r = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Strap level is set before reset so the model settles in time
	task automatic do_reset(input logic [1:0] s);
		strap_sel <= s;
		resetn <= 1'b0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (14) @(posedge core_clk);
	endtask

	// Case bits: [1:0] mode, [2] parallel, [3] monitor, [4] CMI
	function automatic logic [3:0] expect_route(input logic [4:0] c);
		logic [3:0] r;
		if (c[2]) begin
			r = {1'b0, c[1:0] == 2'h3, 1'b1, 1'b0};
		end else begin
			r = {1'b0, c[1:0] == 2'h3, c[1:0] != 2'h1, c[1] ^ c[0]};
		end
		r[3] = c[3] & c[4];
		return r;
	endfunction

	task automatic close_out();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(20318));
		// Defaults loaded from each strap state
		for (int i = 0; i < 3; i++) begin
			do_reset(straps[i]);
			wb(1'b0, ttms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
			check("strap default", q, 32'({dflt[i], 3'h0}));
			check("reset route", 32'({gain, loop_t, fifo, cru}),
				32'(expect_route({3'h0, dflt[i]})));
		end
		$display("test strap_defaults done");
		// Every code in both interfaces, then random cases
		for (int i = 0; i < 48; i++) begin
			v = (i < 32) ? i[4:0] : 5'($urandom);
			par <= v[2];
			cmi <= v[4];
			wb(1'b1, ttms_pkg::ADDR_MODE, 4'h1, 32'({v[1:0], v[3], 2'h0}), q);
			repeat (3) @(posedge core_clk);
			check("route", 32'({gain, loop_t, fifo, cru}),
				32'(expect_route(v)));
			wb(1'b0, ttms_pkg::ADDR_STAT, 4'hf, 32'h0, q);
			check("status", q, 32'(expect_route(v)));
			wb(1'b0, ttms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
			check("mode readback", q, 32'({v[1:0], v[3], 2'h0}));
		end
		$display("test mode_table done");
		// One full mode write, then refused accesses that must leave the mode alone
		par <= 1'b0;
		cmi <= 1'b1;
		wb(1'b1, ttms_pkg::ADDR_MODE, 4'hf, 32'h0000001c, q);
		wb(1'b1, ttms_pkg::ADDR_MODE, 4'he, 32'h00000000, q);
		wb(1'b1, ttms_pkg::ADDR_STAT, 4'hf, 32'h00000000, q);
		wb(1'b0, 4'h8, 4'hf, 32'h0, q);
		check("unmapped read", q, 32'h0);
		wb(1'b0, ttms_pkg::ADDR_MODE, 4'hf, 32'h0, q);
		check("mode kept", q, 32'h0000001c);
		wb(1'b0, ttms_pkg::ADDR_STAT, 4'hf, 32'h0, q);
		check("status kept", q, 32'(expect_route(5'h1b)));
		$display("test refused_access done");
		close_out();
	end
endmodule

`default_nettype wire
